/* verilog/sic_consts.vh */
// Behaviour
// - With slot capability enabled, initial-value fields load into live slot control fields.
// - Partition reset keeps live slot fields; fundamental reset loads them from initial values.
// - With slot capability enabled, a write to an initial-value field updates the live slot field at once.
// - Bit 4 is command-complete irq enable init, RW, reset zero, kept over soft reset.
// - Bit 5 is hot-plug irq enable init, RW, reset zero.
// - Bit 12 is link-active change enable init, reset zero; bits 11, 15:13 reserved.
// - Internal error control bit 0 enables internal error reporting, resets one.
`ifndef SIC_CONSTS_VH
`define SIC_CONSTS_VH
`define SIC_OFF_SCTL_IV 12'h420
`define SIC_OFF_IERR_CTL 12'h480
`define SIC_ADDR_W 12
`define SIC_DATA_W 32
`define SIC_IV_W 16
`define SIC_HTRANS_NONSEQ 2'h2
`define SIC_HSIZE_WORD 3'h2
`define SIC_HRESP_OKAY 1'b0
`define SIC_BIT_CMD_DONE_IE 4
`define SIC_BIT_HOTPLUG_IE 5
`define SIC_ATTN_IND_LSB 6
`define SIC_ATTN_IND_MSB 7
`define SIC_PWR_IND_LSB 8
`define SIC_PWR_IND_MSB 9
`define SIC_BIT_PWR_CTL 10
`define SIC_BIT_LINK_ACT 12
`define SIC_BIT_IERR_EN 0
`define SIC_IV_MASK 16'h17f0
`define SIC_IV_RESET 16'h01c0
`define SIC_IERR_RESET 1'h1
`endif

/* verilog/sic_slot_init_ctl.v */
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "sic_consts.vh"
module sic_slot_init_ctl (
	// Clock and resets
	input wire hclk,
	input wire hresetn,
	input wire part_reset_n,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Slot control
	input wire slot_cap_en,
	output reg [15:0] live_slot_control,
	output reg internal_err_report_en
);
	// Widths
	localparam DW = `SIC_DATA_W;
	localparam IVW = `SIC_IV_W;
	localparam AW = `SIC_ADDR_W;
	localparam SW = 3;

	// Load sequencer states, one-hot
	localparam [SW-1:0] ST_OFF = 3'b001;
	localparam [SW-1:0] ST_LOAD = 3'b010;
	localparam [SW-1:0] ST_TRACK = 3'b100;

	// Offset match used by every decoder
	function hits;
		input [AW-1:0] offset;
		input [AW-1:0] target;
		begin
			hits = offset == target;
		end
	endfunction

	// Keeps only the implemented initial-value fields
	function [IVW-1:0] iv_fields;
		input [DW-1:0] word;
		begin
			iv_fields = word[IVW-1:0] & `SIC_IV_MASK;
		end
	endfunction

	// Keeps only the enable bit of the error control word
	function ierr_field;
		input [DW-1:0] word;
		begin
			ierr_field = word[`SIC_BIT_IERR_EN];
		end
	endfunction

	// Widens the initial-value fields to a bus word
	function [DW-1:0] iv_word;
		input [IVW-1:0] fields;
		begin
			iv_word = {{(DW-IVW){1'b0}}, fields};
		end
	endfunction

	// Widens the enable bit to a bus word
	function [DW-1:0] ierr_word;
		input bit_val;
		begin
			ierr_word = {{(DW-1){1'b0}}, bit_val};
		end
	endfunction

	// Initial values as they stand after this cycle's write
	function [IVW-1:0] iv_after;
		input wr;
		input [IVW-1:0] cur;
		input [IVW-1:0] nxt;
		begin
			iv_after = wr ? nxt : cur;
		end
	endfunction

	// Enable bit as it stands after this cycle's write
	function ierr_after;
		input wr;
		input cur;
		input nxt;
		begin
			ierr_after = wr ? nxt : cur;
		end
	endfunction

	// Registers
	reg [IVW-1:0] iv_q;
	reg ierr_q;
	reg wr_pend_q;
	reg [AW-1:0] wr_addr_q;
	reg [SW-1:0] state_q;
	reg [SW-1:0] state_d;
	reg [IVW-1:0] live_d;
	reg [DW-1:0] rdata_d;
	// Synchronisers
	reg pr_s1_q;
	reg pr_s2_q;
	reg pr_s3_q;
	reg pr_q;
	reg cap_s1_q;
	reg cap_s2_q;
	reg cap_s3_q;
	reg cap_en_q;
	// Decode
	wire addr_ok;
	wire [AW-1:0] a_lo;
	wire rd_req;
	wire wr_req;
	wire rd_iv;
	wire rd_ierr;
	wire iv_wr;
	wire ierr_wr;
	wire [IVW-1:0] iv_next;
	wire ierr_next;
	wire [IVW-1:0] iv_now;
	wire ierr_now;

	assign addr_ok = hsel && hready && htrans == `SIC_HTRANS_NONSEQ && hsize == `SIC_HSIZE_WORD;
	assign a_lo = haddr[AW-1:0];
	assign rd_req = addr_ok && !hwrite;
	assign wr_req = addr_ok && hwrite;
	assign rd_iv = rd_req && hits(a_lo, `SIC_OFF_SCTL_IV);
	assign rd_ierr = rd_req && hits(a_lo, `SIC_OFF_IERR_CTL);
	assign iv_wr = wr_pend_q && hits(wr_addr_q, `SIC_OFF_SCTL_IV);
	assign ierr_wr = wr_pend_q && hits(wr_addr_q, `SIC_OFF_IERR_CTL);
	assign iv_next = iv_fields(hwdata);
	assign ierr_next = ierr_field(hwdata);
	assign iv_now = iv_after(iv_wr, iv_q, iv_next);
	assign ierr_now = ierr_after(ierr_wr, ierr_q, ierr_next);

	// Partition reset pin: three flops, taken once the last two agree
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pr_s1_q <= 1'b1;
			pr_s2_q <= 1'b1;
			pr_s3_q <= 1'b1;
			pr_q <= 1'b1;
		end else begin
			pr_s1_q <= part_reset_n;
			pr_s2_q <= pr_s1_q;
			pr_s3_q <= pr_s2_q;
			if (pr_s2_q == pr_s3_q) begin
				pr_q <= pr_s3_q;
			end
		end
	end

	// Capability enable pin: same three-flop scheme
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cap_s1_q <= 1'b0;
			cap_s2_q <= 1'b0;
			cap_s3_q <= 1'b0;
			cap_en_q <= 1'b0;
		end else begin
			cap_s1_q <= slot_cap_en;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
			if (cap_s2_q == cap_s3_q) begin
				cap_en_q <= cap_s3_q;
			end
		end
	end

	// Address phase: remember a write for its data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= {AW{1'b0}};
		end else begin
			wr_pend_q <= wr_req;
			wr_addr_q <= a_lo;
		end
	end

	// Read data; a write landing in this cycle is forwarded
	always @* begin
		rdata_d = {DW{1'b0}};
		if (rd_iv) begin
			rdata_d = iv_word(iv_now);
		end else if (rd_ierr) begin
			rdata_d = ierr_word(ierr_now);
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= {DW{1'b0}};
		end else begin
			hrdata <= rdata_d;
		end
	end

	// No wait states and always OKAY
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= `SIC_HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp <= `SIC_HRESP_OKAY;
		end
	end

	// Initial-value register; partition reset does not touch it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			iv_q <= `SIC_IV_RESET;
		end else begin
			iv_q <= iv_now;
		end
	end

	// Error reporting control register
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ierr_q <= `SIC_IERR_RESET;
		end else begin
			ierr_q <= ierr_now;
		end
	end

	// Enable output follows the register in the same cycle
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			internal_err_report_en <= `SIC_IERR_RESET;
		end else begin
			internal_err_report_en <= ierr_now;
		end
	end

	// Sequencer: load once on enable, held off while the partition is in reset
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (cap_en_q && pr_q) begin
					state_d = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (cap_en_q) begin
					state_d = ST_TRACK;
				end else begin
					state_d = ST_OFF;
				end
			end
			ST_TRACK: begin
				if (!cap_en_q) begin
					state_d = ST_OFF;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
	end

	// Sequencer state
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// Live copy: loaded from the initial values, then written through
	always @* begin
		live_d = live_slot_control;
		case (state_q)
			ST_LOAD: begin
				live_d = iv_now;
			end
			ST_TRACK: begin
				if (iv_wr) begin
					live_d = iv_next;
				end
			end
			default: begin
				live_d = live_slot_control;
			end
		endcase
	end

	// Partition reset leaves the live copy alone
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			live_slot_control <= `SIC_IV_RESET;
		end else begin
			live_slot_control <= live_d;
		end
	end
endmodule // sic_slot_init_ctl
`default_nettype wire

/* testbench/sic_slot_init_ctl_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module sic_chk(input wire logic hclk,hresetn,hwrite,slot_cap_en,internal_err_report_en,input wire logic [1:0] htrans,
	input wire logic [31:0] haddr,hwdata,hrdata,input wire logic [15:0] live_slot_control);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic g=htrans==2'h2&&hwrite,c=slot_cap_en,w4=g&&haddr[11:0]==12'h420,w8=g&&haddr[11:0]==12'h480;
	wire logic u=htrans==2'h2&&!hwrite&&haddr[11:8]!=4'h4;
	ie_set_a: assert property ($past(w8,2)|->internal_err_report_en==$past(hwdata[0])) else $error("ie");
	ie_kept_a: assert property (!$past(w8,2)|->$stable(internal_err_report_en)) else $error("ie");
	slot_set_a: assert property ($past(w4,2)&&$past(c,8)&&c|->live_slot_control==($past(hwdata[15:0])&16'h17f0))
		else $error("ls");
	slot_kept_a: assert property (!$past(w4,2)&&$past(c,8)==c&&$stable(c)|->$stable(live_slot_control))
		else $error("ls");
	slot_rsv_a: assert property ((live_slot_control&16'he80f)==16'h0) else $error("ls");
	unmapped_a: assert property ($past(u)|->hrdata==32'h0) else $error("rd");
endmodule // sic_chk
bind sic_slot_init_ctl sic_chk u_chk(.*);
`default_nettype wire

/* testbench/sic_slot_init_ctl_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module sic_slot_init_ctl_tb_top;
	logic hclk=0,hresetn=0,part_reset_n=1,hsel=1,hwrite=0,slot_cap_en=0,hreadyout,hresp,internal_err_report_en;
	logic [31:0] haddr=0,hwdata=0,hrdata,r;
	logic [2:0] hsize=3'h2;
	logic [1:0] htrans=0;
	logic [15:0] live_slot_control;
	wire logic hready=hreadyout;
	int failures=0,n_compared=0;
	sic_slot_init_ctl dut(
		.hclk(hclk),
		.hresetn(hresetn),
		.part_reset_n(part_reset_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.slot_cap_en(slot_cap_en),
		.live_slot_control(live_slot_control),
		.internal_err_report_en(internal_err_report_en)
	);
	initial forever #4 hclk=~hclk;
	task close_out;
		$display("failures %0d compared %0d",failures,n_compared);
		if (failures==0&&n_compared>0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task ck(string n,logic [31:0] s,e);
		n_compared++;
		if (s!==e) begin failures++; $display("mismatch %s %h %h",n,e,s); end
	endtask
	task xf(logic w,logic [11:0] a,logic [31:0] d);
		haddr<={20'h0,a}; hwrite<=w; htrans<=2'h2;
		do @(posedge hclk); while (!hready);
		htrans<=2'h0; hwdata<=d;
		do @(posedge hclk); while (!hready);
		r=hrdata;
	endtask
	task t_slot; // Live copy loads on enable, then follows each write
		xf(0,12'h420,32'h0); ck("iv",r,32'h1c0);
		xf(1,12'h420,32'hffffffff); xf(0,12'h484,32'h0); ck("un",r,32'h0);
		ck("ls",{16'h0,live_slot_control},32'h1c0);
		slot_cap_en<=1; repeat(8) @(posedge hclk); ck("ls",{16'h0,live_slot_control},32'h17f0);
		for (int b=4;b<13;b++) begin
			xf(1,12'h420,32'h1<<b); @(posedge hclk); ck("ls",{16'h0,live_slot_control},32'h17f0&1<<b);
		end
	endtask
	task t_ie; // Enable bit, reserved bits, partition reset
		xf(1,12'h480,32'hfffffffe); part_reset_n<=0; repeat(8) @(posedge hclk); part_reset_n<=1;
		xf(0,12'h480,32'h0); ck("ie",r,32'h0);
		ck("en",{31'h0,internal_err_report_en},32'h0);
		ck("ls",{16'h0,live_slot_control},32'h1000);
		xf(1,12'h480,32'hffffffff); xf(0,12'h480,32'h0); ck("ie",r,32'h1);
		ck("en",{31'h0,internal_err_report_en},32'h1);
		ck("rsp",{30'h0,hreadyout,hresp},32'h2);
	endtask
	initial begin
		repeat(16) @(posedge hclk);
		hresetn<=1;
		@(posedge hclk);
		t_slot;
		t_ie;
		close_out;
	end
	initial begin #20000; failures++; close_out; end
endmodule // sic_slot_init_ctl_tb_top
`default_nettype wire
